// >>> rtl/tmr16_pkg.sv
package tmr16_pkg;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_A_LOWER = 8'h04;
  localparam logic [7:0] OFS_A_UPPER = 8'h08;
  localparam logic [7:0] OFS_B_LOWER = 8'h0C;
  localparam logic [7:0] OFS_B_UPPER = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;
  localparam logic [7:0] OFS_CONFIG = 8'h18;
  localparam int BIT_FF = 7;
  localparam int BIT_OPT = 6;
  localparam int BIT_START = 4;
  localparam int BIT_CLK = 2;
  localparam int BIT_MODE = 0;
  localparam int BIT_DIVSEL = 0;
  localparam int BIT_SLOW = 1;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
  localparam int DIV_HI = 11;
  localparam int DIV_MID = 7;
  localparam int DIV_LO = 3;
  localparam int DIV_FS = 3;
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_WINDOW = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h2;
  localparam logic [1:0] MODE_PPG = 2'h3;
  localparam logic [1:0] START_STOP = 2'h0;
  localparam logic [1:0] START_CMD = 2'h1;
  localparam logic [1:0] START_RISE = 2'h2;
  localparam logic [1:0] CLK_SLOWEST = 2'h0;
  localparam logic [1:0] CLK_MID = 2'h1;
  localparam logic [1:0] CLK_FAST = 2'h2;
  localparam logic [1:0] CLK_PIN = 2'h3;

  typedef struct packed {
    logic d_hi;
    logic d_mid;
    logic d_lo;
    logic d_fs;
  } tmr16_ticks_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] cfg;
    logic [7:0] a_lo;
    logic [7:0] a_up;
    logic [7:0] b_lo;
    logic [7:0] b_up;
    logic a_pend;
    logic b_pend;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cnt;
    logic run;
    logic ff;
    logic irq;
    logic act;
    logic hwr;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic rdy;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic stop_s1;
    logic stop_s2;
    logic stop_prev;
  } tmr16_state_t;
endpackage : tmr16_pkg

// >>> rtl/tmr16_presc.sv
`timescale 1ns/100ps
`default_nettype none
module tmr16_presc
  import tmr16_pkg::*;
#(
  parameter int HI = DIV_HI,
  parameter int MID = DIV_MID,
  parameter int LO = DIV_LO,
  parameter int FS = DIV_FS
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic fs_pin,
  output var tmr16_ticks_t ticks
);
  typedef struct packed {
    logic [HI-1:0] div;
    logic [FS-1:0] fdiv;
    logic s1;
    logic s2;
    logic prev;
    tmr16_ticks_t t;
  } tmr16_presc_t;

  tmr16_presc_t s;
  tmr16_presc_t next_s;

  // high-frequency clock is the bus clock; low-frequency clock arrives on a pin
  always_comb
  begin
    next_s = s;
    next_s.div = s.div + 1'b1;
    next_s.s1 = fs_pin;
    next_s.s2 = s.s1;
    next_s.prev = s.s2;
    next_s.t.d_hi = &s.div[HI-1:0];
    next_s.t.d_mid = &s.div[MID-1:0];
    next_s.t.d_lo = &s.div[LO-1:0];
    next_s.t.d_fs = 1'b0;
    if (s.s2 && !s.prev)
    begin
      next_s.fdiv = s.fdiv + 1'b1;
      next_s.t.d_fs = &s.fdiv;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign ticks = s.t;
endmodule : tmr16_presc
`default_nettype wire

// >>> rtl/tmr16_top.sv
`timescale 1ns/100ps
`default_nettype none
module tmr16_top
  import tmr16_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic TIMER_INPUT,
  input wire logic LOW_FREQ_CLK,
  input wire logic STOP_ENTRY,
  output logic TIMER_IRQ,
  output logic TIMER_OUT
);
  tmr16_state_t s;
  tmr16_state_t next_s;
  tmr16_ticks_t tk;
  logic tick;
  logic rise;
  logic fall;
  logic trig;
  logic opp;
  logic stop_hit;
  logic ctl_wr;
  logic [1:0] mode;
  logic [1:0] start;
  logic [1:0] csel;
  logic opt;
  logic ext_trig_mode;
  logic level_ok;
  logic cap_mode;

  tmr16_presc u_presc (
    .clk(CLOCK),
    .rst(RST),
    .fs_pin(LOW_FREQ_CLK),
    .ticks(tk)
  );

  assign mode = s.ctrl[BIT_MODE +: 2];
  assign start = s.ctrl[BIT_START +: 2];
  assign csel = s.ctrl[BIT_CLK +: 2];
  assign opt = s.ctrl[BIT_OPT];
  // edges come from the synchronised copy only
  assign rise = s.pin_s2 && !s.pin_prev;
  assign fall = !s.pin_s2 && s.pin_prev;
  assign trig = (start == START_RISE) ? rise : fall;
  assign opp = (start == START_RISE) ? fall : rise;
  assign stop_hit = s.stop_s2 && !s.stop_prev;
  assign ctl_wr = s.act && s.hwr && (s.addr == OFS_CONTROL);
  assign ext_trig_mode = (mode == MODE_TIMER) && start[1] && (csel != CLK_PIN);
  assign level_ok = (start == START_RISE) ? s.pin_s2 : !s.pin_s2;
  assign cap_mode = ((mode == MODE_TIMER) && !ext_trig_mode) || (mode == MODE_WINDOW);

  // slow mode leaves only the low-frequency source for clock 00
  always_comb
  begin
    unique case (csel)
      CLK_SLOWEST: tick = (s.cfg[BIT_DIVSEL] || s.cfg[BIT_SLOW]) ? tk.d_fs : tk.d_hi;
      CLK_MID: tick = tk.d_mid && !s.cfg[BIT_SLOW];
      CLK_FAST: tick = tk.d_lo && !s.cfg[BIT_SLOW];
      CLK_PIN: tick = trig;
    endcase
  end

  function automatic logic [31:0] read_mux(input tmr16_state_t st, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0;
    unique case (a)
      OFS_CONTROL: r[7:0] = st.ctrl;
      OFS_A_LOWER: r[7:0] = st.cmp_a[7:0];
      OFS_A_UPPER: r[7:0] = st.cmp_a[15:8];
      OFS_B_LOWER: r[7:0] = st.cmp_b[7:0];
      OFS_B_UPPER: r[7:0] = st.cmp_b[15:8];
      OFS_COUNT: r[15:0] = st.cnt;
      OFS_CONFIG: r[1:0] = st.cfg;
      default: r = 32'h0;
    endcase
    return r;
  endfunction : read_mux

  always_comb
  begin
    next_s = s;
    next_s.irq = 1'b0;
    next_s.pin_s1 = TIMER_INPUT;
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_prev = s.pin_s2;
    next_s.stop_s1 = STOP_ENTRY;
    next_s.stop_s2 = s.stop_s1;
    next_s.stop_prev = s.stop_s2;
    next_s.act = 1'b0;
    // address phase; zero wait states, so the read word is ready for the data phase
    if (HSEL && HREADY && HTRANS[1])
    begin
      next_s.act = 1'b1;
      next_s.hwr = HWRITE;
      next_s.addr = HADDR[7:0];
    end
    // a pending 16-bit value lands on a source tick only
    if (tick && s.a_pend)
    begin
      next_s.cmp_a = {s.a_up, s.a_lo};
      next_s.a_pend = 1'b0;
    end
    if (tick && s.b_pend)
    begin
      next_s.cmp_b = {s.b_up, s.b_lo};
      next_s.b_pend = 1'b0;
    end
    unique case (mode)
      MODE_TIMER:
        if (ext_trig_mode)
        begin
          if (!s.run && trig)
          begin
            next_s.run = 1'b1;
            next_s.cnt = 16'h0;
          end
          else if (s.run && opt && opp)
          begin
            next_s.run = 1'b0;
            next_s.cnt = 16'h0;
          end
          else if (s.run && tick)
          begin
            if (s.cnt == s.cmp_a)
            begin
              next_s.run = 1'b0;
              next_s.cnt = 16'h0;
              next_s.irq = 1'b1;
            end
            else
              next_s.cnt = s.cnt + 16'h1;
          end
        end
        else if (start != START_STOP && tick)
        begin
          next_s.run = 1'b1;
          if (s.cnt == s.cmp_a)
          begin
            next_s.cnt = 16'h0;
            next_s.irq = 1'b1;
          end
          else
            next_s.cnt = s.cnt + 16'h1;
        end
      MODE_WINDOW:
        if (start[1] && tick && level_ok)
        begin
          next_s.run = 1'b1;
          if (s.cnt == s.cmp_a)
          begin
            next_s.cnt = 16'h0;
            next_s.irq = 1'b1;
          end
          else
            next_s.cnt = s.cnt + 16'h1;
        end
      MODE_PULSE:
        if (start[1])
        begin
          if (trig)
          begin
            if (s.run && !opt)
            begin
              next_s.cmp_b = s.cnt;
              next_s.irq = 1'b1;
            end
            next_s.run = 1'b1;
            next_s.cnt = 16'h0;
          end
          else if (s.run && opp)
          begin
            next_s.cmp_b = s.cnt;
            next_s.irq = 1'b1;
            if (opt)
              next_s.run = 1'b0;
          end
          else if (s.run && tick)
            next_s.cnt = s.cnt + 16'h1;
        end
      MODE_PPG:
      begin
        // command start fires once, at the control write, so a one-shot stays halted
        if (!s.run && start[1] && trig)
          next_s.run = 1'b1;
        if (s.run && tick)
        begin
          if (s.cnt == s.cmp_b)
            next_s.ff = !s.ff;
          if (s.cnt == s.cmp_a)
          begin
            next_s.ff = !s.ff;
            next_s.cnt = 16'h0;
            next_s.irq = 1'b1;
            if (opt)
              next_s.run = 1'b0;
          end
          else
            next_s.cnt = s.cnt + 16'h1;
        end
      end
    endcase
    // capture follows the counter's own source tick
    if (cap_mode && opt && tick && start != START_STOP)
      next_s.cmp_b = s.cnt;
    // data phase writes; upper byte arms the load, lower byte alone never does
    if (s.act && s.hwr)
    begin
      unique case (s.addr)
        OFS_CONTROL:
        begin
          next_s.ctrl = HWDATA[7:0];
          next_s.ff = HWDATA[BIT_FF];
          if (HWDATA[BIT_START +: 2] == START_STOP)
          begin
            next_s.run = 1'b0;
            next_s.cnt = 16'h0;
            next_s.irq = 1'b0;
          end
          else if (HWDATA[BIT_START +: 2] == START_CMD && HWDATA[BIT_MODE +: 2] == MODE_PPG)
            next_s.run = 1'b1;
        end
        OFS_A_LOWER: next_s.a_lo = HWDATA[7:0];
        OFS_A_UPPER:
        begin
          next_s.a_up = HWDATA[7:0];
          next_s.a_pend = 1'b1;
        end
        OFS_B_LOWER: next_s.b_lo = HWDATA[7:0];
        OFS_B_UPPER:
        begin
          next_s.b_up = HWDATA[7:0];
          next_s.b_pend = 1'b1;
        end
        OFS_CONFIG: next_s.cfg = HWDATA[1:0];
        default: next_s.cfg = next_s.cfg;
      endcase
    end
    // stop entry is applied last so it beats a same-cycle software start
    if (stop_hit)
    begin
      next_s.ctrl[BIT_START +: 2] = START_STOP;
      next_s.run = 1'b0;
      next_s.cnt = 16'h0;
      next_s.irq = 1'b0;
    end
    // read word taken after this edge's updates, so a write just before it is seen
    if (HSEL && HREADY && HTRANS[1] && !HWRITE)
      next_s.rdata = read_mux(next_s, HADDR[7:0]);
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      s <= '0;
      s.ctrl <= CONTROL_RESET;
      s.cmp_a <= COMPARE_RESET;
      s.cmp_b <= COMPARE_RESET;
      s.rdy <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign HRDATA = s.rdata;
  assign HREADYOUT = s.rdy;
  assign HRESP = 1'b0;
  assign TIMER_IRQ = s.irq;
  assign TIMER_OUT = s.ff;

  chk_stop_start: assert property (@(posedge CLOCK) disable iff (RST)
    stop_hit |=> (s.ctrl[BIT_START +: 2] == START_STOP) && !s.run && (s.cnt == 16'h0))
    else $error("stop entry did not clear start field");

  chk_start_idle: assert property (@(posedge CLOCK) disable iff (RST)
    (start == START_STOP) |-> (s.cnt == 16'h0) && !s.irq)
    else $error("counter moved while stopped");

  chk_upper_load: assert property (@(posedge CLOCK) disable iff (RST)
    (tick && s.a_pend) |=> (s.cmp_a == $past({s.a_up, s.a_lo})))
    else $error("compare A not loaded on source tick");

  chk_lower_hold: assert property (@(posedge CLOCK) disable iff (RST)
    (!s.a_pend && !(s.act && s.hwr && s.addr == OFS_A_UPPER)) ##1 !s.a_pend |-> $stable(s.cmp_a))
    else $error("compare A changed without upper write");

  chk_timer_match: assert property (@(posedge CLOCK) disable iff (RST)
    (mode == MODE_TIMER && !ext_trig_mode && start != START_STOP && tick
     && s.cnt == s.cmp_a && !stop_hit && !ctl_wr) |=> (s.cnt == 16'h0) && s.irq)
    else $error("timer match did not clear and interrupt");

  chk_trig_abort: assert property (@(posedge CLOCK) disable iff (RST)
    (ext_trig_mode && s.run && opt && opp && !ctl_wr) |=> !s.run && (s.cnt == 16'h0) && !s.irq)
    else $error("opposite edge did not halt silently");

  chk_trig_keep: assert property (@(posedge CLOCK) disable iff (RST)
    (ext_trig_mode && s.run && !opt && opp && !tick && !ctl_wr && !stop_hit) |=> s.run)
    else $error("opposite edge stopped start-only trigger");

  chk_auto_cap: assert property (@(posedge CLOCK) disable iff (RST)
    (cap_mode && opt && tick && start != START_STOP && !(s.act && s.hwr)) |=>
      (s.cmp_b == $past(s.cnt)))
    else $error("auto-capture missed the counter");

  chk_ff_write: assert property (@(posedge CLOCK) disable iff (RST)
    ctl_wr |=> (TIMER_OUT == $past(HWDATA[BIT_FF])))
    else $error("flip-flop control write not applied");

  chk_ppg_shot: assert property (@(posedge CLOCK) disable iff (RST)
    (mode == MODE_PPG && opt && s.run && tick && s.cnt == s.cmp_a && !ctl_wr)
      |=> !s.run ##1 (s.cnt == 16'h0))
    else $error("one-shot pulse output kept running");

  chk_pulse_single: assert property (@(posedge CLOCK) disable iff (RST)
    (mode == MODE_PULSE && start[1] && opt && s.run && opp && !trig && !ctl_wr && !stop_hit)
      |=> !s.run && s.irq)
    else $error("single-edge capture did not halt");

  chk_window_gate: assert property (@(posedge CLOCK) disable iff (RST)
    (mode == MODE_WINDOW && !level_ok && !ctl_wr && !stop_hit) |=> $stable(s.cnt))
    else $error("window counted outside its level");
endmodule : tmr16_top
`default_nettype wire

// >>> sim/tmr16_pulse_src.sv
`timescale 1ns/100ps
`default_nettype none
module tmr16_pulse_src
(
  input wire logic clk,
  output logic pin
);
  // the source drives the pin at all times, so between pulses it rests low
  initial pin = 1'b0;

  // one pulse, high for hi cycles then low for lo cycles; long or short as asked
  task automatic pulse(input int hi, input int lo);
    @(posedge clk);
    pin <= 1'b1;
    repeat (hi) @(posedge clk);
    pin <= 1'b0;
    repeat (lo) @(posedge clk);
  endtask : pulse
endmodule : tmr16_pulse_src
`default_nettype wire

// >>> sim/tmr16_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tmr16_tb_top;
  import tmr16_pkg::*;
  logic clk, rst, hwrite, stop_in;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic hreadyout, hresp, timer_irq, timer_out, pin, lf_clk;
  int irq_base = 0;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_irq = 0;
  int cyc = 0;
  // rows of {offset, write data, read back}; start codes last so mode edits see start 00
  localparam logic [23:0] ROWS [14] = '{
    {OFS_CONTROL, 16'h0101}, {OFS_CONTROL, 16'h0202}, {OFS_CONTROL, 16'h0303},
    {OFS_CONTROL, 16'h0404}, {OFS_CONTROL, 16'h0808}, {OFS_CONTROL, 16'h0C0C},
    {OFS_CONTROL, 16'h4040}, {OFS_CONTROL, 16'h1010}, {OFS_CONTROL, 16'h2020},
    {OFS_CONTROL, 16'h3030}, {OFS_CONTROL, 16'h0000}, {OFS_CONFIG, 16'h0303},
    {OFS_CONFIG, 16'h0000}, {8'h1C, 16'h5A00}};

  tmr16_top tmr16_top_i (.CLOCK(clk), .RST(rst), .HSEL(1'b1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .TIMER_INPUT(pin),
    .LOW_FREQ_CLK(lf_clk), .STOP_ENTRY(stop_in), .TIMER_IRQ(timer_irq), .TIMER_OUT(timer_out));
  tmr16_pulse_src tmr16_pulse_src_i (.clk(clk), .pin(pin));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("mismatches %0d of %0d compares", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // a hang is cut off well beyond the roughly 1400 cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (timer_irq === 1'b1)
      n_irq++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // entered just after a rising edge; waits on ready, no fixed latency assumed
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 8'h00);
    chk(q, exp);
  endtask : rd_chk

  initial
  begin
    rst <= 1'b1;
    htrans <= 2'h0;
    haddr <= 32'h00000000;
    hwrite <= 1'b0;
    hwdata <= 32'h00000000;
    stop_in <= 1'b0;
    lf_clk <= 1'b0;
    tick(3);
    rst <= 1'b0;
    rd_chk(OFS_CONTROL, 32'h00000000);
    rd_chk(OFS_A_LOWER, 32'h000000FF);
    foreach (ROWS[i])
    begin
      bus(ROWS[i][23:16], 1'b1, ROWS[i][15:8]);
      rd_chk(ROWS[i][23:16], {24'h000000, ROWS[i][7:0]});
    end
    bus(OFS_CONTROL, 1'b1, 8'h08);
    // lower byte alone must leave the live compare value alone
    bus(OFS_A_LOWER, 1'b1, 8'h05);
    tick(20);
    rd_chk(OFS_A_LOWER, 32'h000000FF);
    bus(OFS_A_UPPER, 1'b1, 8'h00);
    tick(20);
    rd_chk(OFS_A_LOWER, 32'h00000005);
    bus(OFS_CONTROL, 1'b1, 8'h18);
    irq_base = n_irq;
    tick(480);
    chk(n_irq - irq_base >= 9 && n_irq - irq_base <= 11, 1);
    bus(OFS_CONTROL, 1'b1, 8'h58);
    tick(40);
    rd_chk(OFS_B_UPPER, 32'h00000000);
    bus(OFS_B_LOWER, 1'b0, 8'h00);
    chk(q <= 5, 1);
    bus(OFS_CONTROL, 1'b1, 8'h08);
    rd_chk(OFS_COUNT, 32'h00000000);
    bus(OFS_CONTROL, 1'b1, 8'h18);
    tick(40);
    stop_in <= 1'b1;
    tick(6);
    rd_chk(OFS_CONTROL, 32'h00000008);
    rd_chk(OFS_COUNT, 32'h00000000);
    stop_in <= 1'b0;
    bus(OFS_CONTROL, 1'b1, 8'h83);
    tick(1);
    chk(timer_out, 1'b1);
    bus(OFS_CONTROL, 1'b1, 8'h03);
    tick(1);
    chk(timer_out, 1'b0);
    bus(OFS_CONTROL, 1'b1, 8'h08);
    bus(OFS_A_LOWER, 1'b1, 8'h50);
    bus(OFS_A_UPPER, 1'b1, 8'h00);
    bus(OFS_CONTROL, 1'b1, 8'h68);
    irq_base = n_irq;
    // the pin falls long before a match, so the count must clear silently
    fork
      tmr16_pulse_src_i.pulse(100, 20);
      begin
        tick(60);
        bus(OFS_COUNT, 1'b0, 8'h00);
        chk(q != 0, 1);
      end
    join
    rd_chk(OFS_COUNT, 32'h00000000);
    chk(n_irq - irq_base, 0);
    bus(OFS_CONTROL, 1'b1, 8'h0C);
    bus(OFS_CONTROL, 1'b1, 8'h2C);
    repeat (3) tmr16_pulse_src_i.pulse(10, 10);
    rd_chk(OFS_COUNT, 32'h00000003);
    // window mode counts prescaled ticks only while the pin is high
    bus(OFS_CONTROL, 1'b1, 8'h0C);
    bus(OFS_CONTROL, 1'b1, 8'h09);
    bus(OFS_CONTROL, 1'b1, 8'h29);
    tick(40);
    rd_chk(OFS_COUNT, 32'h00000000);
    tmr16_pulse_src_i.pulse(80, 8);
    bus(OFS_COUNT, 1'b0, 8'h00);
    chk(q >= 9 && q <= 11, 1);
    // divider select routes eight low-frequency edges to one tick
    bus(OFS_CONTROL, 1'b1, 8'h09);
    bus(OFS_CONTROL, 1'b1, 8'h00);
    bus(OFS_CONFIG, 1'b1, 8'h01);
    bus(OFS_CONTROL, 1'b1, 8'h10);
    repeat (16)
    begin
      lf_clk <= 1'b1;
      tick(4);
      lf_clk <= 1'b0;
      tick(4);
    end
    rd_chk(OFS_COUNT, 32'h00000002);
    bus(OFS_CONTROL, 1'b1, 8'h00);
    bus(OFS_CONFIG, 1'b1, 8'h00);
    // one-shot pulse output: toggle at B, toggle and halt at A
    bus(OFS_CONTROL, 1'b1, 8'h8B);
    bus(OFS_B_LOWER, 1'b1, 8'h03);
    bus(OFS_B_UPPER, 1'b1, 8'h00);
    bus(OFS_A_LOWER, 1'b1, 8'h06);
    bus(OFS_A_UPPER, 1'b1, 8'h00);
    tick(10);
    bus(OFS_CONTROL, 1'b1, 8'hDB);
    irq_base = n_irq;
    tick(42);
    chk(timer_out, 1'b0);
    tick(160);
    chk(n_irq - irq_base, 1);
    chk(timer_out, 1'b1);
    // reset after the one-shot has halted brings the registers back to their reset values
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    rd_chk(OFS_CONTROL, 32'h00000000);
    rd_chk(OFS_A_LOWER, 32'h000000FF);
    chk(timer_out, 1'b0);
    report_and_stop();
  end
endmodule : tmr16_tb_top
`default_nettype wire
